// *** core/bsc_framer_defs.vh ***
// Constants of the binary synchronous framer
`ifndef BSC_FRAMER_DEFS_VH
`define BSC_FRAMER_DEFS_VH
// ==========================================
// Line control codes
`define A_SYN 7'h16
`define A_SOH 7'h01
`define A_STX 7'h02
`define A_ETX 7'h03
`define A_ETB 7'h17
`define A_EOT 7'h04
`define A_ENQ 7'h05
`define A_ACK 7'h06
`define A_NAK 7'h15
`define E_SYN 8'h32
`define E_SOH 8'h01
`define E_STX 8'h02
`define E_ETX 8'h03
`define E_ETB 8'h26
`define E_EOT 8'h37
`define E_ENQ 8'h2D
`define E_ACK 8'h2E
`define E_NAK 8'h3D
`define C_DLE 8'h10
`define C_PAD 8'hFF
`define A_STK_BIT 5
`define E_STK_NONE 2'h0
// ==========================================
// Decoder flag positions
`define D_SYN 0
`define D_SOH 1
`define D_STX 2
`define D_ETX 3
`define D_ABR 4
`define D_ENQ 5
`define D_DLE 6
`define D_STK 7
`define D_WIDTH 8
// ==========================================
// Counts and values
`define CRC_INIT 16'h0000
`define CRC_POLY 16'hA001
`define SYNC_LAST 3'h3
`define BIT_LAST 3'h7
`define BIT_ZERO 3'h0
`define CRC_BYTES 2'h2
`define CRC_ONE 2'h1
`define CRC_NONE 2'h0
`endif

// *** core/bsc_message_framer.v ***
// Binary synchronous message framer with pin samplers and character decoder
`timescale 1ns/1ns
`include "bsc_framer_defs.vh"

// ==========================================
// Pin sampler
module pin_sampler (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire pin,
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  wire agree = (s2_q == s3_q);
  assign rise = agree & s3_q & ~level_q;
  assign fall = agree & ~s3_q & level_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // pin_sampler

// ==========================================
// Character decoder
module char_decoder (
  input wire [7:0] b,
  input wire ebc,
  output wire [`D_WIDTH-1:0] f
);
  assign f[`D_SYN] = ebc ? (b == `E_SYN) : (b[6:0] == `A_SYN);
  assign f[`D_SOH] = ebc ? (b == `E_SOH) : (b[6:0] == `A_SOH);
  assign f[`D_STX] = ebc ? (b == `E_STX) : (b[6:0] == `A_STX);
  assign f[`D_ETX] = ebc ? (b == `E_ETX || b == `E_ETB) : (b[6:0] == `A_ETX || b[6:0] == `A_ETB);
  assign f[`D_ENQ] = ebc ? (b == `E_ENQ) : (b[6:0] == `A_ENQ);
  assign f[`D_ABR] = f[`D_ENQ] | (ebc ? (b == `E_EOT || b == `E_ACK || b == `E_NAK) :
                     (b[6:0] == `A_EOT || b[6:0] == `A_ACK || b[6:0] == `A_NAK));
  assign f[`D_DLE] = (b == `C_DLE);
  assign f[`D_STK] = ebc ? (b[7:6] != `E_STK_NONE) : b[`A_STK_BIT];
endmodule // char_decoder

// ==========================================
// Framer top
// Behaviour
// - ASCII control codes decode on seven bits; escape matches all eight.
// - EBCDIC control codes decode on all eight bits.
// - Escape plus terminator-class byte is a two-byte abrupt terminator.
// - Transmit four sync characters before message bytes.
// - Sync after two syncs; syncs outside transparent text never delivered; next non-sync is data.
// - CRC starts after first SOH or STX, runs until ETX or ETB.
// - After SOH the STX is included in CRC, else CRC starts after it.
// - Transmit two CRC bytes right after ETX or ETB.
// - Receive: ETX/ETB plus two bytes into CRC; nonzero sets error.
// - Receive EOT: store it, then set ready; no CRC follows.
// - Receive ENQ, ACK, NAK exactly like EOT.
// - Transmit bad final character: long message error, then send ENQ.
// - Receive escape plus terminator class: store both, then set ready.
// - Escape then STX enters transparent text for the rest of message.
// - Transparent transmit doubles escapes except the final control escape.
// - Transparent receive drops first escape of pairs; lone controls are data.
// - After SOH, transparent-start escape and STX both enter CRC.
// - Transparent terminating escape never enters CRC; CRC as character mode.
// - Bad transparent end sends escape ENQ; received escape ENQ terminates.
// - No escape-sync fill; late memory data sets DMA error, ends message.
// - Transparent receive discards escape-sync pairs from memory and CRC.
// - CRC-16 with x16+x15+x2+1, sent as two bytes.
// - Character mode CRC covers all but sync once started.
// - ASCII character mode generates and checks odd parity in top bit.
module bsc_message_framer (
  input wire REF_CLK,
  input wire RST,
  input wire CE,
  input wire EBCDIC_SEL,
  input wire RX_MODE,
  input wire GO,
  input wire TX_CLK,
  input wire RX_CLK,
  input wire RX_DATA,
  input wire [7:0] TX_BYTE,
  input wire TX_VALID,
  input wire TX_LAST,
  output reg TX_TAKE,
  output reg TX_DATA,
  output reg [7:0] RX_BYTE,
  output reg RX_STROBE,
  output reg READY,
  output reg SYNC_FOUND,
  output reg CRC_ERR,
  output reg ODD_PARITY_FAIL_FLAG,
  output reg OVERLENGTH_ERROR_FLAG,
  output reg DMA_ERR,
  output reg TRANSPARENT
);
  localparam T_IDLE = 9'h001;
  localparam T_SYNC = 9'h002;
  localparam T_DATA = 9'h004;
  localparam T_DLE = 9'h008;
  localparam T_ENQ = 9'h010;
  localparam T_CRC1 = 9'h020;
  localparam T_CRC2 = 9'h040;
  localparam T_PAD = 9'h080;
  localparam T_FIN = 9'h100;

  reg [8:0] ts_q;
  reg [7:0] sh_q;
  reg [2:0] tbit_q;
  reg [2:0] scnt_q;
  reg [15:0] crc_q;
  reg crc_on_q;
  reg pdle_q;
  reg dle_pend_q;
  reg [7:0] sr_q;
  reg [2:0] rbit_q;
  reg have1_q;
  reg [1:0] rcrc_q;
  reg rx_arm_q;
  reg rx_pend_q;
  reg [7:0] rx_hold_q;
  reg fin_q;
  wire txc_lvl;
  wire txc_fall;
  wire rxc_lvl;
  wire rxc_rise;
  wire rxd_lvl;
  wire [`D_WIDTH-1:0] tf;
  wire [`D_WIDTH-1:0] rf;

  function [15:0] crc8;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] x;
    begin
      x = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (x[0] ^ b[i]) begin
          x = (x >> 1) ^ `CRC_POLY;
        end else begin
          x = x >> 1;
        end
      end
      crc8 = x;
    end
  endfunction

  pin_sampler u_txc (.clk(REF_CLK), .rst(RST), .ce(CE), .pin(TX_CLK), .level_q(txc_lvl), .rise(), .fall(txc_fall));
  pin_sampler u_rxc (.clk(REF_CLK), .rst(RST), .ce(CE), .pin(RX_CLK), .level_q(rxc_lvl), .rise(rxc_rise), .fall());
  pin_sampler u_rxd (.clk(REF_CLK), .rst(RST), .ce(CE), .pin(RX_DATA), .level_q(rxd_lvl), .rise(), .fall());

  wire [7:0] rb = {rxd_lvl, sr_q[7:1]};
  char_decoder u_tdec (.b(TX_BYTE), .ebc(EBCDIC_SEL), .f(tf));
  char_decoder u_rdec (.b(rb), .ebc(EBCDIC_SEL), .f(rf));

  wire par_on = ~EBCDIC_SEL & ~TRANSPARENT;
  wire [7:0] tx_out = par_on ? {~^TX_BYTE[6:0], TX_BYTE[6:0]} : TX_BYTE;
  wire [7:0] syn_out = EBCDIC_SEL ? `E_SYN : {~^`A_SYN, `A_SYN};
  wire [7:0] enq_out = EBCDIC_SEL ? `E_ENQ : {par_on & ~^`A_ENQ, `A_ENQ};
  wire tx_edge = txc_fall & (ts_q != T_IDLE);
  wire tx_load = tx_edge & (tbit_q == `BIT_LAST);
  wire rx_edge = RX_MODE & rxc_rise;
  wire rx_byte = rx_edge & SYNC_FOUND & (rbit_q == `BIT_LAST);

  // ==========================================
  // Framing engine
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ts_q <= T_IDLE;
      sh_q <= `C_PAD;
      tbit_q <= `BIT_ZERO;
      scnt_q <= `BIT_ZERO;
      crc_q <= `CRC_INIT;
      crc_on_q <= 1'b0;
      pdle_q <= 1'b0;
      dle_pend_q <= 1'b0;
      sr_q <= `C_PAD;
      rbit_q <= `BIT_ZERO;
      have1_q <= 1'b0;
      rcrc_q <= `CRC_NONE;
      rx_arm_q <= 1'b0;
      rx_pend_q <= 1'b0;
      rx_hold_q <= `C_PAD;
      fin_q <= 1'b0;
      TX_TAKE <= 1'b0;
      TX_DATA <= 1'b1;
      RX_BYTE <= `C_PAD;
      RX_STROBE <= 1'b0;
      READY <= 1'b1;
      SYNC_FOUND <= 1'b0;
      CRC_ERR <= 1'b0;
      ODD_PARITY_FAIL_FLAG <= 1'b0;
      OVERLENGTH_ERROR_FLAG <= 1'b0;
      DMA_ERR <= 1'b0;
      TRANSPARENT <= 1'b0;
    end else if (CE) begin
      TX_TAKE <= 1'b0;
      RX_STROBE <= 1'b0;
      // Second byte of a pair goes out one cycle later
      if (rx_pend_q) begin
        RX_STROBE <= 1'b1;
        RX_BYTE <= rx_hold_q;
        rx_pend_q <= 1'b0;
      end
      if (fin_q & ~rx_pend_q) begin
        READY <= 1'b1;
        fin_q <= 1'b0;
      end
      // Clears precede the error-flag sets, so those win; the earlier READY set loses
      if (GO & (RX_MODE | (ts_q == T_IDLE))) begin
        READY <= 1'b0;
        CRC_ERR <= 1'b0;
        ODD_PARITY_FAIL_FLAG <= 1'b0;
        OVERLENGTH_ERROR_FLAG <= 1'b0;
        DMA_ERR <= 1'b0;
        if (RX_MODE) begin
          rx_arm_q <= 1'b1;
        end else begin
          ts_q <= T_SYNC;
          tbit_q <= `BIT_LAST;
          sh_q <= `C_PAD;
          scnt_q <= `BIT_ZERO;
          crc_q <= `CRC_INIT;
          crc_on_q <= 1'b0;
          pdle_q <= 1'b0;
          dle_pend_q <= 1'b0;
          TRANSPARENT <= 1'b0;
        end
      end
      // ==========================================
      // Transmit serialiser, data changes on falling clock
      if (tx_edge) begin
        TX_DATA <= sh_q[0];
        tbit_q <= tbit_q + 3'h1;
        sh_q <= {1'b1, sh_q[7:1]};
      end
      if (tx_load) begin
        case (ts_q)
          T_SYNC: begin
            sh_q <= syn_out;
            scnt_q <= scnt_q + 3'h1;
            if (scnt_q == `SYNC_LAST) begin
              ts_q <= T_DATA;
            end
          end
          T_DATA: begin
            if (dle_pend_q & ~(TX_VALID & TX_LAST)) begin
              sh_q <= `C_DLE;
              crc_q <= crc8(crc_q, `C_DLE);
              dle_pend_q <= 1'b0;
            end else if (~TX_VALID) begin
              DMA_ERR <= 1'b1;
              sh_q <= TRANSPARENT ? `C_DLE : enq_out;
              ts_q <= TRANSPARENT ? T_ENQ : T_PAD;
            end else begin
              TX_TAKE <= 1'b1;
              sh_q <= tx_out;
              if (TRANSPARENT) begin
                if (dle_pend_q) begin
                  dle_pend_q <= 1'b0;
                  if (tf[`D_ETX]) begin
                    crc_q <= crc8(crc_q, tx_out);
                    ts_q <= T_CRC1;
                  end else if (tf[`D_ENQ]) begin
                    ts_q <= T_PAD;
                  end else begin
                    OVERLENGTH_ERROR_FLAG <= 1'b1;
                    ts_q <= T_DLE;
                  end
                end else if (tf[`D_DLE] & ~TX_LAST) begin
                  dle_pend_q <= 1'b1;
                end else begin
                  crc_q <= crc8(crc_q, tx_out);
                  if (TX_LAST) begin
                    OVERLENGTH_ERROR_FLAG <= 1'b1;
                    ts_q <= T_DLE;
                  end
                end
              end else begin
                if (crc_on_q & ~tf[`D_SYN]) begin
                  crc_q <= crc8(crc_q, tx_out);
                end
                if (~crc_on_q & (tf[`D_SOH] | tf[`D_STX])) begin
                  crc_on_q <= 1'b1;
                end
                pdle_q <= tf[`D_DLE];
                if (pdle_q & tf[`D_STX]) begin
                  TRANSPARENT <= 1'b1;
                end
                if (TX_LAST) begin
                  if (tf[`D_ETX]) begin
                    ts_q <= T_CRC1;
                  end else if (tf[`D_ABR] | (pdle_q & tf[`D_STK])) begin
                    ts_q <= T_PAD;
                  end else begin
                    OVERLENGTH_ERROR_FLAG <= 1'b1;
                    ts_q <= T_ENQ;
                  end
                end
              end
            end
          end
          T_DLE: begin
            sh_q <= `C_DLE;
            ts_q <= T_ENQ;
          end
          T_ENQ: begin
            sh_q <= enq_out;
            ts_q <= T_PAD;
          end
          T_CRC1: begin
            sh_q <= crc_q[7:0];
            ts_q <= T_CRC2;
          end
          T_CRC2: begin
            sh_q <= crc_q[15:8];
            ts_q <= T_PAD;
          end
          T_PAD: begin
            sh_q <= `C_PAD;
            TRANSPARENT <= 1'b0;
            ts_q <= T_FIN;
          end
          T_FIN: begin
            fin_q <= 1'b1;
            ts_q <= T_IDLE;
          end
          default: begin
            ts_q <= T_IDLE;
          end
        endcase
      end
      // ==========================================
      // Receive deserialiser, sampled on rising clock
      if (~RX_MODE) begin
        SYNC_FOUND <= 1'b0;
        have1_q <= 1'b0;
      end
      if (rx_edge) begin
        sr_q <= rb;
        rbit_q <= rbit_q + 3'h1;
        if (~SYNC_FOUND) begin
          if (rf[`D_SYN]) begin
            rbit_q <= `BIT_ZERO;
            have1_q <= 1'b1;
            if (have1_q & (rbit_q == `BIT_LAST)) begin
              SYNC_FOUND <= 1'b1;
              crc_q <= `CRC_INIT;
              crc_on_q <= 1'b0;
              pdle_q <= 1'b0;
              rcrc_q <= `CRC_NONE;
              TRANSPARENT <= 1'b0;
            end
          end else if (rbit_q == `BIT_LAST) begin
            have1_q <= 1'b0;
          end
        end
      end
      if (rx_byte) begin
        if (par_on & (rcrc_q == `CRC_NONE) & ~^rb) begin
          ODD_PARITY_FAIL_FLAG <= 1'b1;
        end
        if (rcrc_q != `CRC_NONE) begin
          crc_q <= crc8(crc_q, rb);
          rcrc_q <= rcrc_q - 2'h1;
          if (rcrc_q == `CRC_ONE) begin
            if (crc8(crc_q, rb) != `CRC_INIT) begin
              CRC_ERR <= 1'b1;
            end
            SYNC_FOUND <= 1'b0;
            have1_q <= 1'b0;
            fin_q <= 1'b1;
            rx_arm_q <= 1'b0;
          end
        end else if (TRANSPARENT) begin
          if (pdle_q) begin
            pdle_q <= 1'b0;
            if (~rf[`D_SYN]) begin
              RX_STROBE <= rx_arm_q;
              RX_BYTE <= `C_DLE;
              DMA_ERR <= DMA_ERR | ~rx_arm_q;
              if (rf[`D_DLE]) begin
                crc_q <= crc8(crc_q, `C_DLE);
              end else begin
                rx_pend_q <= rx_arm_q;
                rx_hold_q <= rb;
                if (~rf[`D_ENQ]) begin
                  crc_q <= crc8(crc_q, rb);
                end
                if (rf[`D_ETX]) begin
                  rcrc_q <= `CRC_BYTES;
                  TRANSPARENT <= 1'b0;
                end
                if (rf[`D_ENQ]) begin
                  TRANSPARENT <= 1'b0;
                  SYNC_FOUND <= 1'b0;
                  have1_q <= 1'b0;
                  fin_q <= 1'b1;
                  rx_arm_q <= 1'b0;
                end
              end
            end
          end else if (rf[`D_DLE]) begin
            pdle_q <= 1'b1;
          end else begin
            RX_STROBE <= rx_arm_q;
            RX_BYTE <= rb;
            DMA_ERR <= DMA_ERR | ~rx_arm_q;
            crc_q <= crc8(crc_q, rb);
          end
        end else if (~rf[`D_SYN]) begin
          // Unarmed buffer: byte lost and flagged
          RX_STROBE <= rx_arm_q;
          RX_BYTE <= rb;
          DMA_ERR <= DMA_ERR | ~rx_arm_q;
          if (crc_on_q) begin
            crc_q <= crc8(crc_q, rb);
          end
          if (~crc_on_q & (rf[`D_SOH] | rf[`D_STX])) begin
            crc_on_q <= 1'b1;
          end
          pdle_q <= rf[`D_DLE];
          if (pdle_q & rf[`D_STX]) begin
            TRANSPARENT <= 1'b1;
          end
          if (rf[`D_ETX]) begin
            rcrc_q <= `CRC_BYTES;
          end
          if (rf[`D_ABR] | (pdle_q & rf[`D_STK])) begin
            SYNC_FOUND <= 1'b0;
            have1_q <= 1'b0;
            fin_q <= 1'b1;
            rx_arm_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule // bsc_message_framer

// *** tb/bsc_framer_properties.sv ***
// Port-level assertions for the message framer
`timescale 1ns/1ns
module bsc_framer_properties (
  input wire REF_CLK,
  input wire RST,
  input wire GO,
  input wire RX_MODE,
  input wire EBCDIC_SEL,
  input wire TX_CLK,
  input wire TX_VALID,
  input wire TX_TAKE,
  input wire TX_DATA,
  input wire [7:0] RX_BYTE,
  input wire RX_STROBE,
  input wire READY,
  input wire CRC_ERR,
  input wire ODD_PARITY_FAIL_FLAG,
  input wire OVERLENGTH_ERROR_FLAG,
  input wire DMA_ERR,
  input wire TRANSPARENT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Assertions
  // fetch needs data
  take_valid_a: assert property (TX_TAKE |-> $past(TX_VALID)) else $error("take without data");
  take_in_tx_a: assert property (TX_TAKE |-> !RX_MODE && !READY) else $error("take outside transmit");
  eot_ready_a: assert property (RX_STROBE && !TRANSPARENT &&
    (EBCDIC_SEL ? RX_BYTE == 8'h37 : RX_BYTE[6:0] == 7'h04) |=> READY) else $error("no ready after end");
  no_sync_store_a: assert property (RX_STROBE && !TRANSPARENT |->
    (EBCDIC_SEL ? RX_BYTE != 8'h32 : RX_BYTE[6:0] != 7'h16)) else $error("sync stored");
  ready_hold_a: assert property (READY && !GO |=> READY) else $error("ready dropped");
  go_clear_a: assert property (GO && READY |=> !READY && !CRC_ERR && !DMA_ERR && !OVERLENGTH_ERROR_FLAG)
    else $error("start did not clear");
  tx_edge_a: assert property ($changed(TX_DATA) |-> !TX_CLK) else $error("data moved off clock");
  parity_mode_a: assert property ($rose(ODD_PARITY_FAIL_FLAG) |-> !EBCDIC_SEL && RX_MODE)
    else $error("parity flag in wrong mode");
  long_tx_a: assert property ($rose(OVERLENGTH_ERROR_FLAG) |-> !RX_MODE) else $error("long flag in receive");
  plain_after_a: assert property ($rose(READY) |=> !TRANSPARENT) else $error("transparent after end");
  cover property ($rose(READY) && RX_MODE);
  cover property ($rose(TRANSPARENT));
  cover property ($rose(CRC_ERR));
endmodule // bsc_framer_properties

bind bsc_message_framer bsc_framer_properties bsc_framer_properties_i (.REF_CLK(REF_CLK), .RST(RST), .GO(GO),
  .RX_MODE(RX_MODE), .EBCDIC_SEL(EBCDIC_SEL), .TX_CLK(TX_CLK), .TX_VALID(TX_VALID), .TX_TAKE(TX_TAKE),
  .TX_DATA(TX_DATA), .RX_BYTE(RX_BYTE), .RX_STROBE(RX_STROBE), .READY(READY), .CRC_ERR(CRC_ERR),
  .ODD_PARITY_FAIL_FLAG(ODD_PARITY_FAIL_FLAG), .OVERLENGTH_ERROR_FLAG(OVERLENGTH_ERROR_FLAG),
  .DMA_ERR(DMA_ERR), .TRANSPARENT(TRANSPARENT));

// *** tb/modem_model.sv ***
// Synchronous modem model: link clocks, serial source, serial capture
`timescale 1ns/1ns
module modem_model (
  input wire tx_run,
  input wire tx_data,
  output reg tx_clk,
  output reg rx_clk,
  output reg rx_data
);
  logic bits_q[$];
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rx_data = 1'b1;
  end
  // Least significant bit first
  task send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rx_data = b[i];
      #62 rx_clk = 1'b1;
      #63 rx_clk = 1'b0;
    end
  endtask
  // Released line inverted so no stale bit looks valid
  task end_frame;
    rx_data = ~rx_data;
  endtask
  // Clock only while the bench runs a frame
  always begin
    wait (tx_run);
    #62 tx_clk = 1'b1;
    bits_q.push_back(tx_data);
    #63 tx_clk = 1'b0;
  end
endmodule // modem_model

// *** tb/testbench.sv ***
// Self-checking bench of the message framer
`timescale 1ns/1ns
module testbench;
  logic REF_CLK, RST, GO, RX_MODE, EBCDIC_SEL, tx_run, TX_CLK, RX_CLK, RX_DATA, TX_TAKE, TX_DATA;
  logic RX_STROBE, READY, CRC_ERR, ODD_PARITY_FAIL_FLAG, OVERLENGTH_ERROR_FLAG, DMA_ERR, TRANSPARENT, seen;
  logic SYNC_FOUND;
  logic [7:0] RX_BYTE;
  logic [7:0] mem [0:15];
  logic [7:0] rxq[$], txq[$];
  int tx_len, idx, error_cnt, check_count;
  wire [7:0] TX_BYTE = mem[idx];
  wire TX_VALID = idx < tx_len;
  wire TX_LAST = idx == tx_len - 1;
  bsc_message_framer bsc_message_framer_i (.REF_CLK(REF_CLK), .RST(RST), .CE(1'b1), .EBCDIC_SEL(EBCDIC_SEL),
    .RX_MODE(RX_MODE), .GO(GO), .TX_CLK(TX_CLK), .RX_CLK(RX_CLK), .RX_DATA(RX_DATA), .TX_BYTE(TX_BYTE),
    .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_TAKE(TX_TAKE), .TX_DATA(TX_DATA), .RX_BYTE(RX_BYTE),
    .RX_STROBE(RX_STROBE), .READY(READY), .SYNC_FOUND(SYNC_FOUND), .CRC_ERR(CRC_ERR),
    .ODD_PARITY_FAIL_FLAG(ODD_PARITY_FAIL_FLAG), .OVERLENGTH_ERROR_FLAG(OVERLENGTH_ERROR_FLAG),
    .DMA_ERR(DMA_ERR), .TRANSPARENT(TRANSPARENT));
  modem_model modem_model_i (.tx_run(tx_run), .tx_data(TX_DATA), .tx_clk(TX_CLK), .rx_clk(RX_CLK),
    .rx_data(RX_DATA));
  // ==========================================
  // Memory side and monitors
  always @(posedge REF_CLK) begin
    if (GO)
      idx <= 0;
    else if (TX_TAKE)
      idx <= idx + 1;
    if (RX_STROBE)
      rxq.push_back(RX_BYTE);
    if (TRANSPARENT)
      seen <= 1'b1;
  end
  // ==========================================
  // Helpers
  function logic [15:0] crc(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (d[i])
      for (int j = 0; j < 8; j++)
        c = (c >> 1) ^ ((c[0] ^ d[i][j]) ? 16'hA001 : 16'h0000);
    return c;
  endfunction
  function logic [7:0] par(input logic [7:0] b);
    return {~^b[6:0], b[6:0]};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task flag(input logic f, input logic e);
    chk({7'h00, f}, {7'h00, e});
  endtask
  task cmp(input logic [7:0] g[$], input logic [7:0] e[$]);
    foreach (e[i])
      chk(g[i], e[i]);
  endtask
  task mode(input logic rx, input logic eb);
    @(posedge REF_CLK);
    RX_MODE <= rx;
    EBCDIC_SEL <= eb;
    repeat (4) @(posedge REF_CLK);
  endtask
  task start_op;
    seen = 1'b0;
    rxq = {};
    @(posedge REF_CLK);
    GO <= 1'b1;
    @(posedge REF_CLK);
    GO <= 1'b0;
  endtask
  task wait_ready;
    repeat (2) @(posedge REF_CLK);
    for (int n = 0; n < 5000 && READY !== 1'b1; n++)
      @(posedge REF_CLK);
    flag(READY, 1'b1);
  endtask
  task send_msg(input logic [7:0] m[$]);
    logic [7:0] v;
    int k;
    @(posedge REF_CLK);
    foreach (m[i])
      mem[i] <= m[i];
    tx_len <= m.size();
    modem_model_i.bits_q = {};
    start_op;
    tx_run = 1'b1;
    wait_ready;
    // Last pad bit is captured on the rise after READY
    @(negedge TX_CLK);
    tx_run = 1'b0;
    flag(DMA_ERR, 1'b0);
    txq = {};
    k = 0;
    while (k < modem_model_i.bits_q.size() && modem_model_i.bits_q[k])
      k++;
    for (; k + 8 <= modem_model_i.bits_q.size(); k += 8) begin
      for (int j = 0; j < 8; j++)
        v[j] = modem_model_i.bits_q[k + j];
      txq.push_back(v);
    end
  endtask
  task recv(input logic [7:0] s, input logic [7:0] f[$]);
    start_op;
    modem_model_i.send_byte(s);
    modem_model_i.send_byte(s);
    foreach (f[i])
      modem_model_i.send_byte(f[i]);
    modem_model_i.send_byte(8'hFF);
    modem_model_i.end_frame;
    wait_ready;
    flag(DMA_ERR, 1'b0);
    flag(SYNC_FOUND, 1'b0);
  endtask
  // ==========================================
  // Scenarios
  task t_tx;
    logic [7:0] m[$], e[$], d[$];
    logic [15:0] c;
    m = {8'h01, 8'h5A, 8'h02, 8'hC1, 8'h03};
    c = crc(m[1:$]);
    e = {8'h32, 8'h32, 8'h32, 8'h32, m, c[7:0], c[15:8], 8'hFF};
    send_msg(m);
    cmp(txq, e);
    m = {8'h10, 8'h02, 8'h10, 8'hC1, 8'h10, 8'h03};
    d = {8'h10, 8'hC1, 8'h03};
    c = crc(d);
    e = {8'h32, 8'h32, 8'h32, 8'h32, 8'h10, 8'h02, 8'h10, 8'h10, 8'hC1, 8'h10, 8'h03, c[7:0], c[15:8]};
    send_msg(m);
    cmp(txq, e);
    flag(seen, 1'b1);
    mode(1'b0, 1'b0);
    m = {8'h02, 8'h41};
    e = {8'h16, 8'h16, 8'h16, 8'h16, 8'h02, 8'hC1, 8'h85};
    send_msg(m);
    cmp(txq, e);
    flag(OVERLENGTH_ERROR_FLAG, 1'b1);
    $display("transmit tests done");
  endtask
  task t_rx;
    logic [7:0] f[$], e[$], cd[$], t[$];
    logic [15:0] c;
    mode(1'b1, 1'b1);
    for (int bad = 0; bad < 2; bad++) begin
      e = {8'h02, 8'hC1, 8'h42, 8'h03};
      c = crc(e[1:$]);
      f = {e, c[7:0], c[15:8] ^ 8'(bad)};
      recv(8'h32, f);
      cmp(rxq, e);
      flag(CRC_ERR, bad[0]);
    end
    cd = {8'h5A, 8'h10, 8'h02, 8'h10, 8'h77, 8'h03};
    c = crc(cd);
    f = {8'h01, 8'h5A, 8'h10, 8'h02, 8'h10, 8'h10, 8'h77, 8'h10, 8'h32, 8'h10, 8'h03, c[7:0], c[15:8]};
    recv(8'h32, f);
    e = {8'h01, 8'h5A, 8'h10, 8'h02, 8'h10, 8'h77, 8'h10, 8'h03};
    cmp(rxq, e);
    flag(CRC_ERR, 1'b0);
    flag(seen & ~TRANSPARENT, 1'b1);
    mode(1'b1, 1'b0);
    t = {8'h04, 8'h05, 8'h06, 8'h15};
    foreach (t[k]) begin
      f = {(k == 3) ? 8'h41 : par(8'h41), par(t[k])};
      recv(par(8'h16), f);
      chk({1'b0, rxq[0][6:0]}, 8'h41);
      chk({1'b0, rxq[1][6:0]}, t[k]);
      flag(ODD_PARITY_FAIL_FLAG, k == 3);
    end
    $display("receive tests done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Clock, reset, sequence, watchdog
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  initial begin
    RST = 1'b1;
    GO = 1'b0;
    RX_MODE = 1'b0;
    EBCDIC_SEL = 1'b1;
    tx_run = 1'b0;
    idx = 0;
    tx_len = 0;
    error_cnt = 0;
    check_count = 0;
    foreach (mem[i])
      mem[i] = 8'hFF;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    t_tx;
    t_rx;
    complete_run;
  end
  // Frames take up to about 2k cycles, the whole run about 12k; this leaves wide margin
  initial begin
    #600000;
    error_cnt++;
    complete_run;
  end
endmodule // testbench
